//--- design/cpsc_pkg.sv
/*
 * Constants and types shared by the chip power state control block.
 * Assumes a single 100 MHz clock and a synchronous active-high reset.
 */
package cpsc_pkg;

    // ------------------------------------------------------------
    // Sleep mode encodings
    // ------------------------------------------------------------
    localparam logic [2:0] CPSC_MODE_RUN = 3'h0;
    localparam logic [2:0] CPSC_MODE_LIGHT = 3'h1;
    localparam logic [2:0] CPSC_MODE_PLL_OFF = 3'h2;
    localparam logic [2:0] CPSC_MODE_DEEP = 3'h3;

    // ------------------------------------------------------------
    // Reset values and core gate write count
    // ------------------------------------------------------------
    localparam logic [2:0] CPSC_RST_MODE = 3'h0;
    localparam logic CPSC_RST_BIT = 1'b0;
    localparam logic [1:0] CPSC_CORE_WRITES_NEEDED = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CPSC_CLK_MHZ = 100;
    localparam int CPSC_WAKE_MAX_US = 2000;
    localparam int CPSC_WAKE_CYCLES = CPSC_WAKE_MAX_US * CPSC_CLK_MHZ;
    localparam int CPSC_PLL_LOCK_CYCLES = 1000;
    localparam int CPSC_XTAL_START_CYCLES = 4000;

    typedef enum logic [2:0] {
        CPSC_ST_RUN = 3'b000,
        CPSC_ST_LIGHT = 3'b001,
        CPSC_ST_PLL_OFF = 3'b010,
        CPSC_ST_DEEP = 3'b011,
        CPSC_ST_XTAL_WAIT = 3'b100,
        CPSC_ST_PLL_WAIT = 3'b101
    } cpsc_state_type;

    function automatic logic cpsc_mode_is_sleep(input logic [2:0] mode);
        return (mode == CPSC_MODE_LIGHT) || (mode == CPSC_MODE_PLL_OFF) || (mode == CPSC_MODE_DEEP);
    endfunction : cpsc_mode_is_sleep

endpackage : cpsc_pkg

//--- design/cpsc_sync.sv
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to clk; only the second flop is read.
 */
module cpsc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    import cpsc_pkg::*;

    logic meta;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= CPSC_RST_BIT;
            sync_out <= CPSC_RST_BIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : cpsc_sync

//--- design/cpsc_counter.sv
/*
 * Down counter that reports done once its load value has elapsed.
 * Assumes load and count share clk; load restarts the count.
 */
module cpsc_counter #(
    parameter int WIDTH = 18
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic done
);
    import cpsc_pkg::*;

    logic [WIDTH-1:0] count;
    logic running;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= '0;
            running <= CPSC_RST_BIT;
            done <= CPSC_RST_BIT;
        end else if (load) begin
            count <= load_value;
            running <= 1'b1;
            done <= 1'b0;
        end else if (running) begin
            if (count == '0) begin
                running <= 1'b0;
                done <= 1'b1;
            end else begin
                count <= count - WIDTH'(1);
            end
        end
    end

endmodule : cpsc_counter

//--- design/cpsc_power_control.sv
/*
 * Chip power state control: core clock gate guard, LED disable, and the
 * run/sleep state sequencer with manual and automatic wake.
 * Assumes control bits arrive as write strobes from logic on clk, while
 * host bus pins and the wake notification are asynchronous and synchronised
 * here. This logic sits in an always-on domain clocked from a free source.
 */
// Notes on behaviour
// R1: Core clock off needs two consecutive one-writes
// R2: Zero write restarts the one-write count
// R3: LED off: open-drain released, push-pull inactive
// R4: Configuration held in every power state
// R5: Any chip reset returns to running
// R6: System clocks run only when running
// R7: Light sleep keeps crystal, PLL, network clocks
// R8: PLL-off sleep stops PLL when PHYs down
// R9: Deep sleep stops PLL, crystal, network clocks
// R10: Host powers PHYs down before deep sleep
// R11: Crystal stopped also stops reference output
// R12: Host configures everything before sleep enable
// R13: Mode and sleep enable change separately
// R14: Sleep entry forces ready low
// R15: Host interfaces dead while asleep
// R16: Auto-wake on notification when enabled; the code does not auto-wake from deep sleep
// R17: Parallel write wakes; writes ignored until read
// R18: Host wakes via byte order test register
// R19: Serial select low with clock high wakes
// R20: Host polls test register then ready
// R21: Ready after PLL stable; clear mode, enable
// R22: Wake completes within two milliseconds
// R23: Mode codes 000, 001, 010, 011
// R24: Sleep enable enters selected mode
// R25: Wake detection lives in always-on domain
module cpsc_power_control #(
    parameter int WAKE_CYCLES = cpsc_pkg::CPSC_WAKE_CYCLES,
    parameter int PLL_LOCK_CYCLES = cpsc_pkg::CPSC_PLL_LOCK_CYCLES,
    parameter int XTAL_START_CYCLES = cpsc_pkg::CPSC_XTAL_START_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ctrl_write,
    input wire logic [2:0] wr_sleep_state_select,
    input wire logic wr_mode_valid,
    input wire logic wr_sleep_enter,
    input wire logic wr_auto_wake_enable,
    input wire logic wr_led_outputs_off,
    input wire logic wr_core_clock_gate_off,
    input wire logic wr_core_valid,
    input wire logic host_read_done,
    input wire logic wake_notification,
    input wire logic phy_a_powered_down,
    input wire logic phy_b_powered_down,
    input wire logic pll_locked,
    input wire logic parallel_cs_n,
    input wire logic parallel_wr_n,
    input wire logic parallel_rd_wr,
    input wire logic access_enable_strobe_n,
    input wire logic serial_select_n,
    input wire logic serial_clk,
    input wire logic [1:0] led_in,
    input wire logic [1:0] led_push_pull,
    input wire logic [1:0] led_inactive_level,
    output logic [2:0] sleep_state_select,
    output logic sleep_enter,
    output logic auto_wake_enable,
    output logic led_outputs_off,
    output logic core_clock_gate_off,
    output logic device_ready,
    output logic system_clock_enable,
    output logic pll_enable,
    output logic xtal_enable,
    output logic ref_clock_enable,
    output logic network_clock_enable,
    output logic host_interface_enable,
    output logic host_write_accept,
    output logic wake_timeout,
    output logic [1:0] led_out,
    output logic [1:0] led_oe_n
);
    import cpsc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic cs_n_s, wr_n_s, rd_wr_s, enb_n_s, scs_n_s, sck_s, pme_s;

    cpsc_sync u_sync_cs (.clk(clk), .sys_rst(sys_rst), .async_in(parallel_cs_n), .sync_out(cs_n_s));
    cpsc_sync u_sync_wr (.clk(clk), .sys_rst(sys_rst), .async_in(parallel_wr_n), .sync_out(wr_n_s));
    cpsc_sync u_sync_rw (.clk(clk), .sys_rst(sys_rst), .async_in(parallel_rd_wr), .sync_out(rd_wr_s));
    cpsc_sync u_sync_en (.clk(clk), .sys_rst(sys_rst), .async_in(access_enable_strobe_n), .sync_out(enb_n_s));
    cpsc_sync u_sync_scs (.clk(clk), .sys_rst(sys_rst), .async_in(serial_select_n), .sync_out(scs_n_s));
    cpsc_sync u_sync_sck (.clk(clk), .sys_rst(sys_rst), .async_in(serial_clk), .sync_out(sck_s));
    cpsc_sync u_sync_pme (.clk(clk), .sys_rst(sys_rst), .async_in(wake_notification), .sync_out(pme_s));

    // ------------------------------------------------------------
    // State and control registers
    // ------------------------------------------------------------
    cpsc_state_type state, next_state;
    logic core_one_seen;
    logic writes_locked;

    wire asleep = (state == CPSC_ST_LIGHT) || (state == CPSC_ST_PLL_OFF) || (state == CPSC_ST_DEEP);
    wire waking = (state == CPSC_ST_XTAL_WAIT) || (state == CPSC_ST_PLL_WAIT);
    wire running = (state == CPSC_ST_RUN);

    // Parallel write: select with write strobe, or select with direction and enable
    wire parallel_write_seen = !cs_n_s && (!wr_n_s || (!rd_wr_s && !enb_n_s)); // [R17]
    wire serial_cycle_seen = !scs_n_s && sck_s; // [R19]
    wire manual_wake = asleep && (parallel_write_seen || serial_cycle_seen); // [R25]
    wire auto_wake = asleep && (state != CPSC_ST_DEEP) && auto_wake_enable && pme_s; // [R16] [R9]
    wire wake_now = manual_wake || auto_wake;

    // Writes are only honoured while running and the host path is open
    wire write_ok = ctrl_write && running && !writes_locked; // [R15] [R17]
    wire mode_changes = write_ok && wr_mode_valid && (wr_sleep_state_select != sleep_state_select);
    wire take_mode = mode_changes && !wr_sleep_enter; // [R13]
    wire take_sleep = write_ok && wr_sleep_enter && !mode_changes; // [R13]
    wire enter_sleep = take_sleep && cpsc_mode_is_sleep(sleep_state_select); // [R24]
    wire core_write = write_ok && wr_core_valid;

    // ------------------------------------------------------------
    // Wake-up timers
    // ------------------------------------------------------------
    logic xtal_done, pll_settle_done, wake_guard_done;
    wire xtal_load = manual_wake && (state == CPSC_ST_DEEP) || auto_wake && 1'b0;
    wire pll_load = (state == CPSC_ST_XTAL_WAIT) && xtal_done || wake_now && (state != CPSC_ST_DEEP);

    cpsc_counter #(.WIDTH(18)) u_xtal_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(xtal_load),
        .load_value(18'(XTAL_START_CYCLES)),
        .done(xtal_done)
    );

    // PLL re-stabilisation: hold off ready until counted and locked
    cpsc_counter #(.WIDTH(18)) u_pll_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(pll_load),
        .load_value(18'(PLL_LOCK_CYCLES)),
        .done(pll_settle_done)
    );

    // Flags a wake that overruns its budget
    cpsc_counter #(.WIDTH(18)) u_wake_guard (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(wake_now),
        .load_value(18'(WAKE_CYCLES)),
        .done(wake_guard_done)
    ); // [R22]

    // ------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            CPSC_ST_RUN: begin
                if (enter_sleep) begin
                    next_state = cpsc_state_type'(sleep_state_select); // [R23] [R24]
                end
            end
            CPSC_ST_LIGHT, CPSC_ST_PLL_OFF: begin
                if (wake_now) begin
                    next_state = CPSC_ST_PLL_WAIT;
                end
            end
            CPSC_ST_DEEP: begin
                if (manual_wake) begin
                    next_state = CPSC_ST_XTAL_WAIT; // [R9]
                end
            end
            CPSC_ST_XTAL_WAIT: begin
                if (xtal_done) begin
                    next_state = CPSC_ST_PLL_WAIT;
                end
            end
            CPSC_ST_PLL_WAIT: begin
                if (pll_settle_done && pll_locked) begin
                    next_state = CPSC_ST_RUN; // [R21]
                end
            end
            default: begin
                next_state = CPSC_ST_RUN;
            end
        endcase
    end

    wire wake_complete = (state == CPSC_ST_PLL_WAIT) && (next_state == CPSC_ST_RUN);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= CPSC_ST_RUN; // [R5]
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Configuration fields; held while asleep, mode and sleep enable cleared on wake completion
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_state_select <= CPSC_RST_MODE;
            sleep_enter <= CPSC_RST_BIT;
            auto_wake_enable <= CPSC_RST_BIT;
            led_outputs_off <= CPSC_RST_BIT;
        end else if (wake_complete) begin
            sleep_state_select <= CPSC_MODE_RUN; // [R21]
            sleep_enter <= 1'b0; // [R21]
        end else if (write_ok) begin // [R4]
            if (take_mode) begin
                sleep_state_select <= wr_sleep_state_select;
            end
            if (take_sleep) begin
                sleep_enter <= wr_sleep_enter;
            end
            auto_wake_enable <= wr_auto_wake_enable;
            led_outputs_off <= wr_led_outputs_off;
        end
    end

    // Guarded core clock gate: two back-to-back one-writes to set it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_one_seen <= CPSC_RST_BIT;
            core_clock_gate_off <= CPSC_RST_BIT;
        end else if (core_write) begin
            if (!wr_core_clock_gate_off) begin
                core_one_seen <= 1'b0; // [R2]
                core_clock_gate_off <= 1'b0;
            end else if (core_one_seen) begin
                core_clock_gate_off <= 1'b1; // [R1]
            end else begin
                core_one_seen <= 1'b1; // [R1]
            end
        end
    end

    // After a wake, writes stay locked until the host performs a read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            writes_locked <= CPSC_RST_BIT;
        end else if (enter_sleep) begin
            writes_locked <= 1'b1; // [R17]
        end else if (running && host_read_done) begin
            writes_locked <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Clock gating and status outputs
    // ------------------------------------------------------------
    wire pll_off_req = (state == CPSC_ST_PLL_OFF) && phy_a_powered_down && phy_b_powered_down; // [R8]
    wire next_xtal = !(state == CPSC_ST_DEEP); // [R9]
    wire next_pll = !(state == CPSC_ST_DEEP || state == CPSC_ST_XTAL_WAIT || pll_off_req); // [R7] [R8]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            device_ready <= 1'b1;
            system_clock_enable <= 1'b1;
            pll_enable <= 1'b1;
            xtal_enable <= 1'b1;
            ref_clock_enable <= 1'b1;
            network_clock_enable <= 1'b1;
            host_interface_enable <= 1'b1;
            host_write_accept <= 1'b1;
            wake_timeout <= CPSC_RST_BIT;
        end else begin
            device_ready <= (next_state == CPSC_ST_RUN); // [R14] [R21]
            system_clock_enable <= (next_state == CPSC_ST_RUN); // [R6]
            pll_enable <= next_pll;
            xtal_enable <= next_xtal;
            ref_clock_enable <= next_xtal; // [R11]
            network_clock_enable <= next_xtal; // [R9] [R7]
            host_interface_enable <= !asleep && !waking; // [R15]
            host_write_accept <= running && !writes_locked;
            wake_timeout <= wake_guard_done && waking; // [R22]
        end
    end

    // ------------------------------------------------------------
    // LED pads
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_led
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    led_out[i] <= CPSC_RST_BIT;
                    led_oe_n[i] <= 1'b1;
                end else if (led_outputs_off) begin
                    led_out[i] <= led_inactive_level[i]; // [R3]
                    led_oe_n[i] <= !led_push_pull[i]; // [R3]
                end else begin
                    led_out[i] <= led_in[i];
                    led_oe_n[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule : cpsc_power_control

//--- sim/cpsc_checker.sv
/*
 * Port-level assertions for the chip power state control block.
 * Assumes one clock and a synchronous active-high reset; bound below.
 */
module cpsc_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ctrl_write,
    input wire logic [2:0] wr_sleep_state_select,
    input wire logic wr_mode_valid,
    input wire logic wr_sleep_enter,
    input wire logic wr_core_clock_gate_off,
    input wire logic wr_core_valid,
    input wire logic phy_a_powered_down,
    input wire logic phy_b_powered_down,
    input wire logic [1:0] led_push_pull,
    input wire logic [1:0] led_inactive_level,
    input wire logic [2:0] sleep_state_select,
    input wire logic sleep_enter,
    input wire logic led_outputs_off,
    input wire logic core_clock_gate_off,
    input wire logic device_ready,
    input wire logic system_clock_enable,
    input wire logic pll_enable,
    input wire logic xtal_enable,
    input wire logic ref_clock_enable,
    input wire logic network_clock_enable,
    input wire logic host_interface_enable,
    input wire logic host_write_accept,
    input wire logic wake_timeout,
    input wire logic [1:0] led_out,
    input wire logic [1:0] led_oe_n
);
    logic taken;
    logic last_zero;
    assign taken = ctrl_write && device_ready && host_write_accept;
    // Count of one-writes is zero after reset or after a zero write
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_zero <= 1'b1;
        end else if (taken && wr_core_valid) begin
            last_zero <= !wr_core_clock_gate_off;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence enter;
        $rose(sleep_enter) && sleep_state_select != 3'h0;
    endsequence
    core_single_a: assert property (taken && wr_core_valid && wr_core_clock_gate_off && last_zero |=>
        !core_clock_gate_off) else $error("core gate set by one write");
    core_zero_a: assert property (taken && wr_core_valid && !wr_core_clock_gate_off |=> !core_clock_gate_off)
        else $error("core gate not cleared");
    led_off_a: assert property (led_outputs_off && $past(led_outputs_off) && $stable(led_push_pull)
        && $stable(led_inactive_level) |-> led_oe_n == ~led_push_pull
        && ((led_out ^ led_inactive_level) & led_push_pull) == 2'h0) else $error("led drive wrong");
    sys_gate_a: assert property (enter |=> !system_clock_enable) else $error("system clock on in sleep");
    light_keep_a: assert property ($rose(sleep_enter) && sleep_state_select == 3'h1 |=>
        (xtal_enable && pll_enable && network_clock_enable) [*3]) else $error("light sleep stopped clocks");
    pll_keep_a: assert property ($rose(sleep_enter) && sleep_state_select == 3'h2
        && !(phy_a_powered_down && phy_b_powered_down) |=> pll_enable && xtal_enable) else $error("pll off early");
    deep_stop_a: assert property ($rose(sleep_enter) && sleep_state_select == 3'h3 |=>
        !xtal_enable && !pll_enable && !network_clock_enable) else $error("deep sleep clocks on");
    ref_stop_a: assert property (!xtal_enable |-> !ref_clock_enable) else $error("reference runs");
    mixed_write_a: assert property (taken && wr_mode_valid && wr_sleep_enter && !sleep_enter
        && wr_sleep_state_select != sleep_state_select |=> !sleep_enter && $stable(sleep_state_select))
        else $error("combined write taken");
    ready_low_a: assert property (enter |=> !device_ready) else $error("ready high in sleep");
    host_off_a: assert property (enter |=> !host_interface_enable) else $error("host on in sleep");
    wake_clear_a: assert property ($rose(device_ready) |-> !sleep_enter && sleep_state_select == 3'h0)
        else $error("fields kept at wake");
    wake_time_a: assert property (!wake_timeout) else $error("wake overrun");
endmodule : cpsc_checker

bind cpsc_power_control cpsc_checker u_checker (.*);

//--- sim/cpsc_host_model.sv
/*
 * Host pins and PLL lock seen from outside the power control block.
 * Assumes go is a one-cycle pulse; released bus pins other than serial_clk idle high (pull-ups).
 */
module cpsc_host_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [3:0] lock_dly,
    input wire logic pll_enable,
    output logic wake_notification,
    output logic parallel_cs_n,
    output logic parallel_wr_n,
    output logic parallel_rd_wr,
    output logic access_enable_strobe_n,
    output logic serial_select_n,
    output logic serial_clk,
    output logic pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold = 4'h0;
    logic [3:0] lock_count = 4'h0;
    logic active;
    // Cycle held long enough to pass the two-flop synchronisers
    always @(posedge clk) begin
        if (go) begin
            hold <= 4'h8;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
        lock_count <= !pll_enable ? 4'h0 : (lock_count == lock_dly ? lock_count : lock_count + 4'h1);
    end
    assign active = hold != 4'h0;
    assign wake_notification = active && kind == 2'h1;
    assign parallel_cs_n = !(active && kind[1]);
    assign parallel_wr_n = !(active && kind == 2'h2);
    assign parallel_rd_wr = !(active && kind == 2'h3);
    assign access_enable_strobe_n = !(active && kind == 2'h3);
    assign serial_select_n = !(active && kind == 2'h0);
    // Serial clock toggles only inside the frame
    assign serial_clk = active && kind == 2'h0 && hold[0];
    assign pll_locked = pll_enable && lock_count == lock_dly;
endmodule : cpsc_host_model

//--- sim/test_chip_power_state_control.sv
/*
 * Self-checking bench for the chip power state control block.
 * Assumes short wake counts; the host model drives pins and PLL lock.
 */
module test_chip_power_state_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE = 500;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ctrl_write = 1'b0, wr_mode_valid = 1'b0, wr_sleep_enter = 1'b0, wr_auto_wake_enable = 1'b0;
    logic wr_led_outputs_off = 1'b0, wr_core_clock_gate_off = 1'b0, wr_core_valid = 1'b0, host_read_done = 1'b0;
    logic phy_a_powered_down = 1'b0, phy_b_powered_down = 1'b0, go = 1'b0;
    logic [2:0] wr_sleep_state_select = 3'h0;
    logic [1:0] led_in = 2'h0, led_push_pull = 2'h0, led_inactive_level = 2'h0, kind = 2'h0;
    logic [3:0] lock_dly = 4'h3;
    logic wake_notification, parallel_cs_n, parallel_wr_n, parallel_rd_wr, access_enable_strobe_n;
    logic serial_select_n, serial_clk, pll_locked, sleep_enter, auto_wake_enable, led_outputs_off;
    logic core_clock_gate_off, device_ready, system_clock_enable, pll_enable, xtal_enable, ref_clock_enable;
    logic network_clock_enable, host_interface_enable, host_write_accept, wake_timeout;
    logic [2:0] sleep_state_select;
    logic [1:0] led_out, led_oe_n;
    int num_errors = 0;
    int checked = 0;

    cpsc_power_control #(.WAKE_CYCLES(WAKE), .PLL_LOCK_CYCLES(10), .XTAL_START_CYCLES(20)) dut (
        .clk, .sys_rst, .ctrl_write, .wr_sleep_state_select, .wr_mode_valid, .wr_sleep_enter, .wr_auto_wake_enable,
        .wr_led_outputs_off, .wr_core_clock_gate_off, .wr_core_valid, .host_read_done, .wake_notification,
        .phy_a_powered_down, .phy_b_powered_down, .pll_locked, .parallel_cs_n, .parallel_wr_n, .parallel_rd_wr,
        .access_enable_strobe_n, .serial_select_n, .serial_clk, .led_in, .led_push_pull, .led_inactive_level,
        .sleep_state_select, .sleep_enter, .auto_wake_enable, .led_outputs_off, .core_clock_gate_off, .device_ready,
        .system_clock_enable, .pll_enable, .xtal_enable, .ref_clock_enable, .network_clock_enable,
        .host_interface_enable, .host_write_accept, .wake_timeout, .led_out, .led_oe_n
    );
    cpsc_host_model host (
        .clk, .go, .kind, .lock_dly, .pll_enable, .wake_notification, .parallel_cs_n, .parallel_wr_n,
        .parallel_rd_wr, .access_enable_strobe_n, .serial_select_n, .serial_clk, .pll_locked
    );

    initial begin
        forever #5 clk = ~clk;
    end

    // Expected {crystal, pll, network, system} enables while asleep
    function automatic logic [3:0] exp_clk(input logic [2:0] m, input logic down);
        case (m)
            3'h1: return 4'he;
            3'h2: return {1'b1, !down, 2'b10};
            3'h3: return 4'h0;
            default: return 4'hf;
        endcase
    endfunction : exp_clk

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic results;
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [2:0] m, input logic mv, se, aw, led, core, cv);
        @(posedge clk);
        ctrl_write <= 1'b1;
        wr_sleep_state_select <= m;
        wr_mode_valid <= mv;
        wr_sleep_enter <= se;
        wr_auto_wake_enable <= aw;
        wr_led_outputs_off <= led;
        wr_core_clock_gate_off <= core;
        wr_core_valid <= cv;
        @(posedge clk);
        ctrl_write <= 1'b0;
        #1;
    endtask : wr

    task automatic pulse(input logic [1:0] k);
        @(posedge clk);
        kind <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : pulse

    task automatic sleep_cycle(input logic [2:0] m, input logic [1:0] k, input logic down);
        int n;
        logic [3:0] e;
        e = exp_clk(m, down);
        @(posedge clk);
        phy_a_powered_down <= down;
        phy_b_powered_down <= down;
        lock_dly <= 4'($urandom_range(12, 1));
        wr(m, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        wr(m, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        chk({1'b0, ref_clock_enable, device_ready, host_interface_enable, xtal_enable, pll_enable,
            network_clock_enable, system_clock_enable}, {1'b0, e[3], 2'b00, e}, "sleep");
        if (m == 3'h3) begin
            pulse(2'h1);
            repeat (20) @(posedge clk);
            #1;
            chk({7'h0, device_ready}, 8'h00, "deep auto wake");
        end
        pulse(k);
        n = 0;
        while (device_ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
        if (n >= 2000) begin
            num_errors++;
            $display("mismatch at %0t: wake hang", $time);
            results();
        end
        chk({7'h0, n < WAKE}, 8'h01, "wake time");
        chk({1'b0, sleep_state_select, sleep_enter, auto_wake_enable, led_outputs_off, host_write_accept},
            8'h06, "after wake");
        wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({7'h0, led_outputs_off}, 8'h01, "locked write");
        @(posedge clk);
        host_read_done <= 1'b1;
        phy_a_powered_down <= 1'b0;
        phy_b_powered_down <= 1'b0;
        @(posedge clk);
        host_read_done <= 1'b0;
        wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({6'h0, auto_wake_enable, led_outputs_off}, 8'h00, "write after read");
    endtask : sleep_cycle

    initial begin
        logic [4:0] core_in;
        logic [4:0] core_exp;
        core_in = 5'b01101;
        core_exp = 5'b01000;
        void'($urandom(91029));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk({sleep_state_select, sleep_enter, core_clock_gate_off, device_ready, system_clock_enable, xtal_enable},
            8'h07, "reset");
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, core_in[i], 1'b1);
            chk({7'h0, core_clock_gate_off}, {7'h0, core_exp[i]}, "core gate");
        end
        repeat (8) begin
            @(posedge clk);
            led_push_pull <= 2'($urandom);
            led_inactive_level <= 2'($urandom);
            led_in <= 2'($urandom);
            wr(3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
            repeat (2) @(posedge clk);
            #1;
            chk({4'h0, led_oe_n, led_out & led_push_pull},
                {4'h0, ~led_push_pull, led_inactive_level & led_push_pull}, "led");
        end
        wr(3'h1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk({4'h0, sleep_state_select, sleep_enter}, 8'h00, "combined write");
        sleep_cycle(3'h1, 2'h1, 1'b0);
        sleep_cycle(3'h2, 2'h2, 1'b1);
        sleep_cycle(3'h2, 2'h3, 1'b0);
        sleep_cycle(3'h3, 2'h0, 1'b1);
        results();
    end
endmodule : test_chip_power_state_control
